/* tswdt_top.sv */
// two-stage watchdog timer with apb register slave
// Notes on behaviour
// - 32-bit down counter; zero is first time-out
// - interrupt enable also starts the counter
// - reload after first time-out, keep counting
// - second zero with pending flag resets system
// - clearing before second zero reloads counter
// - reload write loads counter at once
// - reload write leaves pending flag alone
// - only clear register write clears flag
// - enabling interrupt preloads from reload value
// - separate interrupt and reset enables
// - lock writes protect; key unlocks
// - control ignores writes once interrupt enabled
// - unlocked clear write clears and reloads; a same-cycle time-out re-sets the flag
// - zero reload raises interrupt immediately
//
// Added by the designer: the address map and the APB slave port.
module tswdt_top
   import tswdt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // to interrupt and reset controllers
   output logic timeout_irq,
   output logic irq,
   output logic wdog_reset
);
   typedef struct packed {
      logic [31:0] reload_value;
      logic timeout_irq_enable;
      logic reset_output_enable;
      logic timeout_pending;
      logic write_protected;
      logic [1:0] status;
      logic [1:0] mask;
      logic [7:0] rst_cnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic timeout_irq;
      logic irq;
      logic wdog_reset;
   } tswdt_state_s;

   tswdt_state_s st;
   tswdt_state_s next_st;
   logic cnt_load;
   logic [31:0] cnt_load_value;
   logic [31:0] count;
   logic at_zero;

   // ==========================================================
   // address decode
   function automatic logic mapped(input logic [11:0] a);
      case (a)
         reload_value_off, current_value_off, watchdog_control_off, timeout_flag_clear_off,
         raw_status_off, masked_status_off, irq_mask_off, reset_cause_off,
         write_protect_key_off: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction : mapped

   // first access-phase cycle registers the answer; access completes with pready
   wire logic access = psel && penable && !st.pready;
   wire logic wr = access && pwrite && mapped(paddr);
   wire logic rd = access && !pwrite;
   // the key register stays writable so software can always unlock
   wire logic wr_open = wr && !st.write_protected;
   wire logic wr_reload = wr_open && paddr == reload_value_off;
   wire logic wr_ctl = wr_open && paddr == watchdog_control_off && !st.timeout_irq_enable;
   wire logic wr_clear = wr_open && paddr == timeout_flag_clear_off;
   wire logic wr_w1c = wr_open && paddr == reset_cause_off;
   wire logic wr_mask = wr_open && paddr == irq_mask_off;
   wire logic wr_key = wr && paddr == write_protect_key_off;
   wire logic enabling = wr_ctl && pwdata[ctl_irq_enable_bit] && !st.timeout_irq_enable;
   wire logic second_timeout = at_zero && st.timeout_pending;

   // ==========================================================
   // counter load select
   always_comb begin
      cnt_load = 1'b0;
      cnt_load_value = st.reload_value;
      if (wr_reload) begin
         cnt_load = 1'b1;
         cnt_load_value = pwdata;
      end else if (enabling || wr_clear) begin
         cnt_load = 1'b1;
      end else if (at_zero) begin
         cnt_load = 1'b1;
      end
   end

   tswdt_counter u_counter (
      .clk(clk),
      .reset(reset),
      .load(cnt_load),
      .load_value(cnt_load_value),
      .run(st.timeout_irq_enable),
      .count(count),
      .at_zero(at_zero)
   );

   // ==========================================================
   // state update
   always_comb begin
      next_st = st;
      next_st.pready = access;
      next_st.pslverr = access && !mapped(paddr);
      next_st.prdata = 32'h00000000;
      if (wr_reload) begin
         next_st.reload_value = pwdata;
      end
      if (wr_ctl) begin
         next_st.reset_output_enable = pwdata[ctl_reset_enable_bit];
         next_st.timeout_irq_enable = pwdata[ctl_irq_enable_bit];
      end
      if (wr_key) begin
         next_st.write_protected = (pwdata != unlock_key);
      end
      if (wr_mask) begin
         next_st.mask = pwdata[1:0];
      end
      // clear wins only against no event; a same-cycle time-out re-sets the flag
      if (wr_clear) begin
         next_st.timeout_pending = 1'b0;
      end
      if (wr_w1c) begin
         next_st.status = st.status & ~pwdata[1:0];
      end
      // a zero reload reports at once via at_zero on the next cycle
      if (at_zero && st.timeout_irq_enable) begin
         next_st.timeout_pending = 1'b1;
         next_st.status[status_timeout_bit] = 1'b1;
      end
      if (second_timeout && st.timeout_irq_enable && st.reset_output_enable) begin
         next_st.rst_cnt = wdog_reset_cycles;
         next_st.status[status_reset_bit] = 1'b1;
      end else if (st.rst_cnt != 8'h00) begin
         next_st.rst_cnt = st.rst_cnt - 8'h01;
      end
      next_st.wdog_reset = (next_st.rst_cnt != 8'h00);
      next_st.timeout_irq = next_st.timeout_pending && next_st.timeout_irq_enable;
      next_st.irq = |(next_st.status & next_st.mask);
      if (rd) begin
         case (paddr)
            reload_value_off: next_st.prdata = st.reload_value;
            current_value_off: next_st.prdata = count;
            watchdog_control_off: next_st.prdata = {30'h0, st.reset_output_enable, st.timeout_irq_enable};
            raw_status_off: next_st.prdata = {31'h0, st.timeout_pending};
            masked_status_off: next_st.prdata = {31'h0, st.timeout_pending && st.timeout_irq_enable};
            irq_mask_off: next_st.prdata = {30'h0, st.mask};
            reset_cause_off: next_st.prdata = {30'h0, st.status};
            write_protect_key_off: next_st.prdata = st.write_protected ? locked_status : unlocked_status;
            default: next_st.prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
         st.reload_value <= reload_reset;
         st.mask <= irq_mask_reset;
      end else begin
         st <= next_st;
      end
   end

   assign prdata = st.prdata;
   assign pready = st.pready;
   assign pslverr = st.pslverr;
   assign timeout_irq = st.timeout_irq;
   assign irq = st.irq;
   assign wdog_reset = st.wdog_reset;
endmodule : tswdt_top

/* tswdt_pkg.sv */
// package of register map, field layout and reset values for the two-stage watchdog
package tswdt_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [11:0] reload_value_off = 12'h000;
   localparam logic [11:0] current_value_off = 12'h004;
   localparam logic [11:0] watchdog_control_off = 12'h008;
   localparam logic [11:0] timeout_flag_clear_off = 12'h00c;
   localparam logic [11:0] raw_status_off = 12'h010;
   localparam logic [11:0] masked_status_off = 12'h014;
   localparam logic [11:0] irq_mask_off = 12'h018;
   localparam logic [11:0] reset_cause_off = 12'h01c;
   localparam logic [11:0] write_protect_key_off = 12'hc00;
   // ==========================================================
   // fields and values
   localparam int ctl_irq_enable_bit = 0;
   localparam int ctl_reset_enable_bit = 1;
   localparam logic [31:0] unlock_key = 32'h1acce551;
   localparam logic [31:0] reload_reset = 32'hffffffff;
   localparam logic [31:0] locked_status = 32'h00000001;
   localparam logic [31:0] unlocked_status = 32'h00000000;
   localparam logic [1:0] irq_mask_reset = 2'h3;
   localparam int wdog_reset_pulse_ns = 100;
   localparam int clk_period_ns = 5;
   localparam logic [7:0] wdog_reset_cycles = 8'((wdog_reset_pulse_ns + clk_period_ns - 1) / clk_period_ns);
   localparam int status_timeout_bit = 0;
   localparam int status_reset_bit = 1;
endpackage : tswdt_pkg

/* tswdt_counter.sv */
// 32-bit down counter with reload and zero detect, registered outputs
module tswdt_counter
   import tswdt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic load,
   input wire logic [31:0] load_value,
   input wire logic run,
   // state
   output logic [31:0] count,
   output logic at_zero
);
   typedef struct packed {
      logic [31:0] count;
      logic at_zero;
   } tswdt_cnt_s;

   tswdt_cnt_s st;
   tswdt_cnt_s next_st;

   always_comb begin
      next_st = st;
      next_st.at_zero = 1'b0;
      if (load) begin
         next_st.count = load_value;
         next_st.at_zero = (load_value == 32'h00000000);
      end else if (run && st.count != 32'h00000000) begin
         next_st.count = st.count - 32'h00000001;
         next_st.at_zero = (st.count == 32'h00000001);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st.count <= reload_reset;
         st.at_zero <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.count;
   assign at_zero = st.at_zero;
endmodule : tswdt_counter

/* tswdt_checker.sv */
// port assertions for the two-stage watchdog
module tswdt_checker (
   // clock, reset, apb
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // system side
   input wire logic timeout_irq,
   input wire logic irq,
   input wire logic wdog_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_wr; psel && pwrite; endsequence
   property p_answer; s_wait |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no ready after access");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_rdzero; !pready |-> prdata == 32'h0; endproperty
   a_rdzero: assert property (p_rdzero) else $error("read data outside ready");
   property p_lockrd; pready && !pwrite && paddr == 12'hc00 |-> prdata[31:1] == 31'h0; endproperty
   a_lockrd: assert property (p_lockrd) else $error("lock status not 0 or 1");
   property p_rstlen; $rose(wdog_reset) |-> wdog_reset [*8]; endproperty
   a_rstlen: assert property (p_rstlen) else $error("system reset too short");
   property p_rstcause; $rose(wdog_reset) |-> $past(timeout_irq); endproperty
   a_rstcause: assert property (p_rstcause) else $error("reset without pending time-out");
   property p_clronly; $fell(timeout_irq) |-> $past(psel && pwrite, 1) || $past(psel && pwrite, 2); endproperty
   a_clronly: assert property (p_clronly) else $error("time-out dropped without write");
   property p_irqev; $rose(timeout_irq) |-> ##[0:2] irq; endproperty
   a_irqev: assert property (p_irqev) else $error("event interrupt missing");
   property p_errpulse; pslverr |-> pready; endproperty
   a_errpulse: assert property (p_errpulse) else $error("error flag outside ready");
endmodule : tswdt_checker

bind tswdt_top tswdt_checker u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .timeout_irq(timeout_irq), .irq(irq), .wdog_reset(wdog_reset));

/* tswdt_sys_model.sv */
// system reset controller model: counts watchdog reset requests
module tswdt_sys_model (
   // clock, reset and request
   input wire logic clk,
   input wire logic reset,
   input wire logic reset_req,
   output int resets
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev;
   // one count per request, however long the pulse
   always @(posedge clk) begin
      prev <= reset_req;
      if (reset) resets <= 0;
      else if (reset_req && !prev) resets <= resets + 1;
   end
endmodule : tswdt_sys_model

/* tb_top.sv */
// self-checking testbench for the two-stage watchdog
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_top
   import tswdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, timeout_irq, irq, wdog_reset;
   int fail_count = 0, checked = 0, resets;
   tswdt_top dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeout_irq(timeout_irq),
      .irq(irq), .wdog_reset(wdog_reset));
   tswdt_sys_model sys (.clk(clk), .reset(reset), .reset_req(wdog_reset), .resets(resets));
   // the block clock gate is taken as enabled for the whole run
   initial forever #2.5 clk = ~clk;
   // ==========================
   // bus and wait helpers
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic do_reset;
      reset <= 1;
      repeat (10) @(posedge clk);
      reset <= 0;
      @(posedge clk);
   endtask : do_reset
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (n >= 20) begin
         fail_count++;
         test_done();
      end
      @(posedge clk);
   endtask : apb
   task automatic wait_out(input logic sel, input int lim);
      int n;
      n = 0;
      while ((sel ? wdog_reset : timeout_irq) !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            fail_count++;
            test_done();
         end
      end
   endtask : wait_out
   // ==========================
   // scenarios
   task automatic t_lock;
      apb(0, reload_value_off, 32'h0);
      `CHK("reload", reload_reset, rd)
      apb(0, watchdog_control_off, 32'h0);
      `CHK("ctl", 32'h0, rd)
      apb(1, write_protect_key_off, 32'h0);
      apb(0, write_protect_key_off, 32'h0);
      `CHK("lock", locked_status, rd)
      apb(1, reload_value_off, 32'h55);
      apb(0, reload_value_off, 32'h0);
      `CHK("locked", reload_reset, rd)
      apb(1, write_protect_key_off, unlock_key);
      apb(0, write_protect_key_off, 32'h0);
      `CHK("unlock", unlocked_status, rd)
      apb(0, 12'h020, 32'h0);
      `CHK("slverr", 1'b1, err)
   endtask : t_lock
   task automatic t_two_stage;
      apb(1, reload_value_off, 32'h3c);
      apb(1, watchdog_control_off, 32'h3);
      wait_out(0, 100);
      apb(0, current_value_off, 32'h0);
      `CHK("reloaded", 1'b1, rd > 32'h28)
      apb(1, watchdog_control_off, 32'h0);
      apb(0, watchdog_control_off, 32'h0);
      `CHK("ctl", 32'h3, rd)
      apb(1, reload_value_off, 32'h1f4);
      `CHK("pend", 1'b1, timeout_irq)
      apb(0, current_value_off, 32'h0);
      `CHK("new", 1'b1, rd > 32'h1c2)
      `CHK("irq", 1'b1, irq)
      apb(1, irq_mask_off, 32'h0);
      `CHK("masked", 1'b0, irq)
      apb(1, irq_mask_off, 32'h3);
      apb(1, reset_cause_off, 32'h1);
      `CHK("wc", 1'b0, irq)
      apb(1, timeout_flag_clear_off, 32'h0);
      `CHK("clr", 1'b0, timeout_irq)
      wait_out(0, 600);
      `CHK("nores", 0, resets)
      wait_out(1, 600);
      @(posedge clk);
      `CHK("res", 1, resets)
   endtask : t_two_stage
   task automatic t_zero_reload;
      apb(1, watchdog_control_off, 32'h1);
      apb(1, reload_value_off, 32'h0);
      wait_out(0, 10);
      repeat (40) @(posedge clk);
      `CHK("nores", 0, resets)
   endtask : t_zero_reload
   initial begin
      do_reset();
      t_lock();
      t_two_stage();
      do_reset();
      t_zero_reload();
      test_done();
   end
endmodule : tb_top
